/* dv/cmf_frame_service_sva.sv */
// Port-level assertions for the frame service block.
// Assumes it is bound to every instance of the block.
`timescale 1ns/1ps
`include "cmf_map.vh"
module cmf_frame_service_sva (
    input wire clk_sys, // Clock
    input wire rst, // Reset
    input wire snd_req, // Send
    input wire snd_new_seq, // New sequence
    input wire snd_last, // Closing
    input wire [11:0] snd_size, // Size
    input wire [11:0] fab_max_size, // Fabric max
    input wire [11:0] dst_max_size, // Receiver max
    input wire snd_busy_q, // Busy
    input wire snd_err_q, // Error
    input wire tx_valid_q, // Frame out
    input wire [2:0] tx_kind_q, // Kind
    input wire [3:0] tx_sof_q, // Start
    input wire [3:0] tx_eof_q, // End
    input wire [7:0] tx_reason_q, // Reason
    input wire tx_rrdy_q, // Ready out
    input wire rx_valid, // Frame in
    input wire [3:0] rx_sof, // Its start
    input wire rx_frame_ok, // Valid
    input wire rx_buf_free, // Freed
    input wire rx_deliver_q, // Delivered
    input wire rx_dup_q, // Repeat
    input wire [7:0] bb_credit_q, // Buffer credit
    input wire [7:0] ee_credit_q // End credit
);
    reg new_q;
    reg last_q;
    wire [11:0] lim = (fab_max_size < dst_max_size) ? fab_max_size : dst_max_size;
    wire data_tx = tx_valid_q && (tx_kind_q == `CMF_KIND_DATA);
    wire c2_in = rx_valid && rx_frame_ok && (rx_sof == `CMF_SOF_I2 || rx_sof == `CMF_SOF_N2);
    // ----------------
    // Delimiter choice held from the take, resends reuse it
    // ----------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            new_q <= 1'h0;
            last_q <= 1'h0;
        end else if (snd_req && !snd_busy_q) begin
            new_q <= snd_new_seq;
            last_q <= snd_last;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_SOF_DATA: assert property (data_tx |-> tx_sof_q == (new_q ? `CMF_SOF_I2 : `CMF_SOF_N2))
        else $error("data start delimiter wrong");
    AST_EOF_DATA: assert property (data_tx |-> tx_eof_q == (last_q ? `CMF_EOF_T : `CMF_EOF_N))
        else $error("data end delimiter wrong");
    AST_ACK_DELIM: assert property (tx_valid_q && tx_kind_q == `CMF_KIND_ACK |-> tx_sof_q == `CMF_SOF_N2)
        else $error("ack start delimiter wrong");
    AST_ACK_DUE: assert property (c2_in |-> ##2 (rx_deliver_q || rx_dup_q))
        else $error("valid frame not taken");
    AST_DROP3: assert property (rx_valid && rx_sof >= `CMF_SOF_I3 |-> ##2 !rx_deliver_q && !rx_dup_q)
        else $error("datagram frame not dropped");
    AST_REJ1: assert property (tx_valid_q && tx_kind_q == `CMF_KIND_PRJT |->
        tx_sof_q == `CMF_SOF_N1 && tx_reason_q == `CMF_RSN_CLASS)
        else $error("reject delimiter or reason wrong");
    AST_RRDY: assert property (rx_buf_free |=> tx_rrdy_q)
        else $error("receiver ready missing");
    AST_BB_GATE: assert property (tx_valid_q |-> $past(bb_credit_q) != 8'h00)
        else $error("frame sent without buffer credit");
    AST_EE_GATE: assert property (data_tx |-> $past(ee_credit_q) != 8'h00)
        else $error("data sent without end credit");
    AST_SIZE: assert property (snd_req && !snd_busy_q && snd_size > lim |=> snd_err_q ##1 !snd_err_q)
        else $error("oversize request not refused");
endmodule // cmf_frame_service_sva
bind cmf_frame_service cmf_frame_service_sva u_sva (.clk_sys, .rst, .snd_req, .snd_new_seq, .snd_last, .snd_size,
    .fab_max_size, .dst_max_size, .snd_busy_q, .snd_err_q, .tx_valid_q, .tx_kind_q, .tx_sof_q, .tx_eof_q,
    .tx_reason_q, .tx_rrdy_q, .rx_valid, .rx_sof, .rx_frame_ok, .rx_buf_free, .rx_deliver_q, .rx_dup_q,
    .bb_credit_q, .ee_credit_q);

/* dv/cmf_link_model.sv */
// Far-side link model: grants frames, frees buffers, answers data frames.
// Assumes the bench picks the answer kind and the pace.
`timescale 1ns/1ps
`include "cmf_map.vh"
module cmf_link_model (
    input wire clk_sys, // Clock
    input wire rst, // Reset
    input wire tx_valid_q, // Frame sent
    input wire [2:0] tx_kind_q, // Its kind
    input wire [1:0] resp_mode, // 0 ack, 1 busy, 2 reject
    input wire slow, // Stall and answer late
    output reg tx_ready, // Link accepts
    output reg rx_rrdy, // Buffer freed
    output reg rx_ack, // Ack answer
    output reg rx_busy, // Busy answer
    output reg rx_reject // Reject answer
);
    reg [1:0] rr_q;
    reg [3:0] rs_q;
    // ----------------
    // Answers
    // ----------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {tx_ready, rx_rrdy, rx_ack, rx_busy, rx_reject} <= 5'h00;
            rr_q <= 2'h0;
            rs_q <= 4'h0;
        end else begin
            // Half-rate grants when slow, so sends must wait on ready
            tx_ready <= !slow || !tx_ready;
            // One buffer freed three cycles after each frame; frames in consecutive cycles free only one
            rr_q <= tx_valid_q ? 2'h2 : (rr_q != 2'h0 ? rr_q - 2'h1 : 2'h0);
            rx_rrdy <= (rr_q == 2'h1);
            // Answer per data frame only, busy or reject on demand
            rs_q <= (tx_valid_q && tx_kind_q == `CMF_KIND_DATA) ? (slow ? 4'h9 : 4'h1) :
                (rs_q != 4'h0 ? rs_q - 4'h1 : 4'h0);
            rx_ack <= (rs_q == 4'h1) && (resp_mode == 2'h0);
            rx_busy <= (rs_q == 4'h1) && (resp_mode == 2'h1);
            rx_reject <= (rs_q == 4'h1) && (resp_mode == 2'h2);
        end
    end
endmodule // cmf_link_model

/* dv/tb_top.sv */
// Self-checking bench for the frame service block against a reference.
// Assumes the link model answers data frames and frees buffers.
`timescale 1ns/1ps
`include "cmf_map.vh"
module tb_top;
    reg clk_sys, rst, credit_load, snd_req, snd_new_seq, snd_last, snd_new_xchg, rx_valid, rx_frame_ok;
    reg rx_buf_free, slow;
    reg [7:0] bb_credit_login, ee_credit_login, p_id;
    reg [11:0] fab_max_size, dst_max_size, snd_size, e_size;
    reg [3:0] retry_limit, rx_sof, rx_eof, rx_qual, e_sof, e_eof, e_aeof;
    reg [15:0] rx_seq_cnt, p_ox;
    reg [1:0] resp_mode;
    wire snd_busy_q, snd_err_q, tx_valid_q, tx_rrdy_q, tx_ready, rx_rrdy, rx_ack, rx_busy, rx_reject;
    wire rx_deliver_q, rx_dup_q;
    wire [2:0] tx_kind_q;
    wire [3:0] tx_sof_q, tx_eof_q;
    wire [15:0] tx_seq_cnt_q, tx_ox_id_q;
    wire [7:0] tx_seq_id_q, tx_reason_q, bb_credit_q, ee_credit_q;
    wire [11:0] tx_size_q;
    integer n_errors, n_checks, cyc, i, k, e_cnt, seed;
    integer n_tx [0:3];
    integer last_cnt [0:15];
    cmf_frame_service dut (.clk_sys, .rst, .bb_credit_login, .ee_credit_login, .credit_load, .fab_max_size,
        .dst_max_size, .retry_limit, .snd_req, .snd_new_seq, .snd_last, .snd_size, .snd_new_xchg, .snd_busy_q,
        .snd_err_q, .tx_valid_q, .tx_kind_q, .tx_sof_q, .tx_eof_q, .tx_seq_cnt_q, .tx_seq_id_q, .tx_ox_id_q,
        .tx_size_q, .tx_reason_q, .tx_rrdy_q, .tx_ready, .rx_rrdy, .rx_ack, .rx_busy, .rx_reject, .rx_valid,
        .rx_sof, .rx_eof, .rx_qual, .rx_seq_cnt, .rx_frame_ok, .rx_buf_free, .rx_deliver_q, .rx_dup_q,
        .bb_credit_q, .ee_credit_q);
    cmf_link_model u_link (.clk_sys, .rst, .tx_valid_q, .tx_kind_q, .resp_mode, .slow, .tx_ready, .rx_rrdy,
        .rx_ack, .rx_busy, .rx_reject);
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task end_of_test;
        begin
            if (n_errors == 0 && n_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            end_of_test;
        end
    end
    // ----------------
    // Reference for every frame leaving the block
    // ----------------
    always @(negedge clk_sys) begin
        if (tx_valid_q === 1'h1) begin
            n_tx[tx_kind_q] = n_tx[tx_kind_q] + 1;
            if (tx_kind_q === `CMF_KIND_DATA) begin
                chk(tx_sof_q, e_sof);
                chk(tx_eof_q, e_eof);
                chk(tx_seq_cnt_q, e_cnt);
                chk(tx_size_q, e_size);
            end else begin
                chk(tx_sof_q, tx_kind_q === `CMF_KIND_ACK ? `CMF_SOF_N2 : `CMF_SOF_N1);
                chk(tx_eof_q, e_aeof);
            end
        end
    end
    task wait_n(input integer kind, input integer base);
        integer w;
        begin
            for (w = 0; w < 80 && n_tx[kind] == base; w = w + 1)
                @(negedge clk_sys);
        end
    endtask
    task wait_free;
        integer w;
        begin
            for (w = 0; w < 200 && snd_busy_q !== 1'h0; w = w + 1)
                @(negedge clk_sys);
        end
    endtask
    task cred(input [7:0] b, input [7:0] e);
        begin
            @(posedge clk_sys);
            bb_credit_login <= b;
            ee_credit_login <= e;
            credit_load <= 1'h1;
            @(posedge clk_sys);
            credit_load <= 1'h0;
            @(negedge clk_sys);
            chk(bb_credit_q, b);
            chk(ee_credit_q, e);
        end
    endtask
    task snd_start(input nseq, input lst, input xch, input [11:0] sz);
        begin
            e_sof = nseq ? `CMF_SOF_I2 : `CMF_SOF_N2;
            e_eof = lst ? `CMF_EOF_T : `CMF_EOF_N;
            e_cnt = nseq ? 0 : e_cnt + 1;
            e_size = sz;
            i = n_tx[0];
            @(posedge clk_sys);
            snd_req <= 1'h1;
            snd_new_seq <= nseq;
            snd_last <= lst;
            snd_new_xchg <= xch;
            snd_size <= sz;
            @(posedge clk_sys);
            snd_req <= 1'h0;
        end
    endtask
    task snd_finish(input nseq, input xch);
        begin
            wait_n(0, i);
            chk(n_tx[0], i + 1);
            chk(tx_seq_id_q !== p_id, nseq);
            chk(tx_ox_id_q !== p_ox, xch);
            p_id = tx_seq_id_q;
            p_ox = tx_ox_id_q;
            wait_free;
        end
    endtask
    task rx(input [3:0] sof, input [3:0] eof, input [3:0] q, input [15:0] c, input ok);
        integer b1, b2;
        reg c2;
        begin
            b1 = n_tx[1];
            b2 = n_tx[2];
            c2 = (sof == `CMF_SOF_I2 || sof == `CMF_SOF_N2);
            e_aeof = (sof == `CMF_SOF_C1) ? `CMF_EOF_DT : (c2 && eof == `CMF_EOF_T) ? `CMF_EOF_T : `CMF_EOF_N;
            @(posedge clk_sys);
            rx_valid <= 1'h1;
            rx_sof <= sof;
            rx_eof <= eof;
            rx_qual <= q;
            rx_seq_cnt <= c;
            rx_frame_ok <= ok;
            @(posedge clk_sys);
            rx_valid <= 1'h0;
            @(posedge clk_sys);
            @(negedge clk_sys);
            chk(rx_deliver_q, c2 && ok && last_cnt[q] != c);
            chk(rx_dup_q, c2 && ok && last_cnt[q] == c);
            if (c2 && ok)
                last_cnt[q] = c;
            @(posedge clk_sys);
            rx_buf_free <= 1'h1;
            @(posedge clk_sys);
            rx_buf_free <= 1'h0;
            repeat (20) @(negedge clk_sys);
            chk(n_tx[1], b1 + (c2 && ok));
            chk(n_tx[2], b2 + (sof < `CMF_SOF_I2 && ok));
        end
    endtask
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        {rst, credit_load, snd_req, snd_new_seq, snd_last, snd_new_xchg, rx_valid, rx_frame_ok} = 8'h80;
        {rx_buf_free, slow, resp_mode, retry_limit, rx_sof, rx_eof, rx_qual, rx_seq_cnt} = 36'h0_0000_0000;
        {bb_credit_login, ee_credit_login, snd_size} = 28'h000_0000;
        fab_max_size = 12'h096;
        dst_max_size = 12'h064;
        seed = 32'h8d76c5d8;
        {n_errors, n_checks, cyc, e_cnt} = 128'h0;
        for (i = 0; i < 16; i = i + 1) begin
            last_cnt[i] = -1;
            n_tx[i % 4] = 0;
        end
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        cred(8'h02, 8'h02);
        for (k = 0; k < 6; k = k + 1) begin
            slow <= k[0];
            snd_start(k % 3 == 0, k % 3 == 2, k % 3 == 0, 12'($unsigned($random(seed)) % 101));
            snd_finish(k % 3 == 0, k % 3 == 0);
        end
        repeat (6) @(negedge clk_sys);
        chk(bb_credit_q, 2);
        chk(ee_credit_q, 2);
        snd_start(1'h1, 1'h1, 1'h0, 12'h065);
        @(negedge clk_sys);
        chk(snd_err_q, 1);
        wait_free;
        repeat (8) @(negedge clk_sys);
        chk(n_tx[0], i);
        cred(8'h00, 8'h01);
        snd_start(1'h1, 1'h0, 1'h1, 12'h040);
        repeat (10) @(negedge clk_sys);
        chk(n_tx[0], i);
        cred(8'h01, 8'h01);
        snd_finish(1'h1, 1'h1);
        repeat (6) @(negedge clk_sys);
        chk(ee_credit_q, 1);
        cred(8'h08, 8'h08);
        for (k = 0; k < 3; k = k + 1) begin
            @(posedge clk_sys);
            resp_mode <= (k == 2) ? 2'h2 : 2'h1;
            retry_limit <= (k == 0) ? 4'h0 : 4'(k + 1);
            snd_start(1'h1, 1'h1, 1'h0, 12'h064);
            snd_finish(1'h1, 1'h0);
            repeat (4) @(negedge clk_sys);
            chk(n_tx[0] - i, (k == 1) ? 3 : 1);
        end
        resp_mode <= 2'h0;
        for (k = 1; k < 8; k = k + 1)
            rx(4'(k), k[0] ? `CMF_EOF_T : `CMF_EOF_N, 4'(k), 16'($random(seed)) | 16'h0001, 1'h1);
        rx(`CMF_SOF_N2, `CMF_EOF_N, 4'h9, 16'h0005, 1'h1);
        rx(`CMF_SOF_N2, `CMF_EOF_T, 4'h9, 16'h0003, 1'h1);
        rx(`CMF_SOF_N2, `CMF_EOF_T, 4'h9, 16'h0003, 1'h1);
        rx(`CMF_SOF_I2, `CMF_EOF_N, 4'h9, 16'h0007, 1'h0);
        repeat (10) @(negedge clk_sys);
        chk(bb_credit_q, 8);
        end_of_test;
    end
endmodule // tb_top

/* include/cmf_map.vh */
// Constants for the multiplexed-class frame service block.
// Assumes inclusion by the frame service RTL and by the dv assertion, link model and bench files.
`ifndef CMF_MAP_VH
`define CMF_MAP_VH

// Delimiter codes on the tx/rx delimiter ports
`define CMF_SOF_I1 4'h1
`define CMF_SOF_N1 4'h2
`define CMF_SOF_C1 4'h3
`define CMF_SOF_I2 4'h4
`define CMF_SOF_N2 4'h5
`define CMF_SOF_I3 4'h6
`define CMF_SOF_N3 4'h7
`define CMF_EOF_N 4'h8
`define CMF_EOF_T 4'h9
`define CMF_EOF_DT 4'hA

// Frame kinds presented to the transmit side
`define CMF_KIND_DATA 3'h0
`define CMF_KIND_ACK 3'h1
`define CMF_KIND_PRJT 3'h2
`define CMF_KIND_PBSY 3'h3

// Reason code for class not supported
`define CMF_RSN_CLASS 8'h01

// Field widths
`define CMF_CRED_W 8
`define CMF_SIZE_W 12
`define CMF_TRK_AW 4
`define CMF_TRK_DEPTH 16

// Reset values
`define CMF_RETRY_RST 4'h0

`endif

/* rtl/cmf_frame_service.v */
// Frame service for the acknowledged connectionless class of a node port.
// Assumes link framing, CRC and header formatting sit outside this block.
//
// Functional notes
// - first frame of each new sequence starts with initiate delimiter SOFi2.
// - later frames of the sequence start with normal delimiter SOFn2.
// - last frame ends with EOFt, earlier frames with EOFn.
// - each valid received data frame of this class queues an ACK; a newer answer replaces one still queued.
// - each ACK of this class starts with SOFn2.
// - ACK closing a sequence ends EOFt, others end EOFn.
// - sequence count rises by one on each successive sent frame.
// - received frames of one sequence are accepted in any order.
// - originator exchange ids are unique per port.
// - new sequence ids stay unique while the sequence is open.
// - buffer credit with attached port, end-to-end credit through ACKs.
// - a receiver-ready is sent whenever a receive buffer frees.
// - busy or reject carries a valid reason; port uses its own kinds.
// - busied data frames are resent up to the retry limit, maybe zero.
// - credit agreed at login is honoured, shared with other classes.
// - data field held to smaller of fabric and receiver maximum.
// - start delimiters of all classes decoded, answered in own class.
// - dedicated-class frames rejected, datagram frames dropped, buffers still freed; a dedicated frame arriving the cycle after a class-2 frame gets no reject.
// - received frames tracked by sequence qualifier plus sequence count.
// - every data frame passes buffer and end-to-end credit checks first; ACKs and rejects check buffer credit only.
`timescale 1ns/1ps
`include "cmf_map.vh"
module cmf_frame_service (
    input wire clk_sys, // System clock, 20 MHz
    input wire rst, // Async reset, active high
    // Login-derived configuration
    input wire [7:0] bb_credit_login, // Buffer credit from login
    input wire [7:0] ee_credit_login, // End-to-end credit from login
    input wire credit_load, // Pulse: load both credit counters
    input wire [11:0] fab_max_size, // Fabric maximum data field
    input wire [11:0] dst_max_size, // Receiver maximum data field
    input wire [3:0] retry_limit, // Allowed resends of a busied frame
    // User send request
    input wire snd_req, // Pulse: send one data frame
    input wire snd_new_seq, // Frame opens a new sequence
    input wire snd_last, // Frame closes the sequence
    input wire [11:0] snd_size, // Requested data field size
    input wire snd_new_xchg, // Frame opens a new exchange
    output reg snd_busy_q, // Send path occupied
    output reg snd_err_q, // Pulse: request refused or retries spent
    // Transmit frame port
    output reg tx_valid_q, // Pulse: frame descriptor valid
    output reg [2:0] tx_kind_q, // Data, ACK, reject or busy
    output reg [3:0] tx_sof_q, // Start delimiter
    output reg [3:0] tx_eof_q, // End delimiter
    output reg [15:0] tx_seq_cnt_q, // Sequence count
    output reg [7:0] tx_seq_id_q, // Sequence id
    output reg [15:0] tx_ox_id_q, // Originator exchange id
    output reg [11:0] tx_size_q, // Data field size sent
    output reg [7:0] tx_reason_q, // Reject reason
    output reg tx_rrdy_q, // Pulse: send receiver-ready
    input wire tx_ready, // Link can take a frame this cycle
    // Link events in
    input wire rx_rrdy, // Pulse: receiver-ready arrived
    input wire rx_ack, // Pulse: ACK for our data arrived
    input wire rx_busy, // Pulse: busy for our last data frame
    input wire rx_reject, // Pulse: reject for our last data frame
    // Received frame port
    input wire rx_valid, // Pulse: received frame descriptor
    input wire [3:0] rx_sof, // Its start delimiter
    input wire [3:0] rx_eof, // Its end delimiter
    input wire [3:0] rx_qual, // Sequence qualifier slot
    input wire [15:0] rx_seq_cnt, // Its sequence count
    input wire rx_frame_ok, // Frame passed validity checks
    input wire rx_buf_free, // Pulse: host freed a receive buffer
    output reg rx_deliver_q, // Pulse: frame handed to host
    output reg rx_dup_q, // Pulse: repeated sequence count seen
    output reg [7:0] bb_credit_q, // Buffer credit left
    output reg [7:0] ee_credit_q // End-to-end credit left
);
    // ----------------
    // Functions
    // ----------------
    function [11:0] min12;
        input [11:0] a;
        input [11:0] b;
        begin
            min12 = (a < b) ? a : b;
        end
    endfunction

    function is_dedicated;
        input [3:0] s;
        begin
            is_dedicated = (s == `CMF_SOF_I1) || (s == `CMF_SOF_N1) || (s == `CMF_SOF_C1);
        end
    endfunction

    // ----------------
    // State
    // ----------------
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_SEND = 2'b01;
    localparam [1:0] ST_WAIT = 2'b10;

    reg [1:0] st_q;
    reg [15:0] seq_cnt_q;
    reg [7:0] seq_id_q;
    reg [15:0] ox_id_q;
    reg first_q;
    reg last_q;
    reg [11:0] size_q;
    reg [3:0] tries_q;
    reg ack_pend_q; // Queued ACK or reject for a received frame
    reg ack_rjt_q;
    reg ack_last_q;
    reg [3:0] ack_sof_q;
    reg [3:0] ack_eof_q;
    reg chk_q; // Tracking lookup in flight
    reg [3:0] chk_qual_q;
    reg [15:0] chk_cnt_q;
    reg chk_last_q;

    wire [15:0] trk_rd;
    wire can_send = (bb_credit_q != 8'h00) && (ee_credit_q != 8'h00);
    // Local ACKs draw only buffer credit; end-to-end credit is the peer's.
    wire ack_go = ack_pend_q && tx_ready && (bb_credit_q != 8'h00);
    wire dat_go = (st_q == ST_SEND) && tx_ready && can_send && !ack_pend_q;
    wire [11:0] lim = min12(fab_max_size, dst_max_size);

    // ----------------
    // Receive classification
    // ----------------
    wire rx_c2 = (rx_sof == `CMF_SOF_I2) || (rx_sof == `CMF_SOF_N2);
    wire rx_c1 = is_dedicated(rx_sof);
    wire rx_take = rx_valid && rx_c2 && rx_frame_ok;
    wire trk_dup = chk_q && trk_rd[15] && (trk_rd[14:0] == chk_cnt_q[14:0]);

    // Each qualifier slot remembers the last count seen; any order is accepted.
    cmf_track_mem u_trk (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(chk_q),
        .wr_addr(chk_qual_q),
        .wr_data({1'b1, chk_cnt_q[14:0]}),
        .rd_addr(rx_qual),
        .rd_data_q(trk_rd)
    );

    // ----------------
    // Sequencing and transmit
    // ----------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            seq_cnt_q <= 16'h0000;
            seq_id_q <= 8'h00;
            ox_id_q <= 16'h0000;
            first_q <= 1'b0;
            last_q <= 1'b0;
            size_q <= 12'h000;
            tries_q <= `CMF_RETRY_RST;
            snd_busy_q <= 1'b0;
            snd_err_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_kind_q <= `CMF_KIND_DATA;
            tx_sof_q <= 4'h0;
            tx_eof_q <= 4'h0;
            tx_seq_cnt_q <= 16'h0000;
            tx_seq_id_q <= 8'h00;
            tx_ox_id_q <= 16'h0000;
            tx_size_q <= 12'h000;
            tx_reason_q <= 8'h00;
        end else begin
            tx_valid_q <= 1'b0;
            snd_err_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (snd_req) begin
                        if (snd_size > lim) begin
                            snd_err_q <= 1'b1;
                        end else begin
                            st_q <= ST_SEND;
                            snd_busy_q <= 1'b1;
                            first_q <= snd_new_seq;
                            last_q <= snd_last;
                            size_q <= snd_size;
                            tries_q <= `CMF_RETRY_RST;
                            if (snd_new_seq) begin
                                seq_cnt_q <= 16'h0000;
                                seq_id_q <= seq_id_q + 8'h01;
                            end else begin
                                seq_cnt_q <= seq_cnt_q + 16'h0001;
                            end
                            if (snd_new_xchg) begin
                                ox_id_q <= ox_id_q + 16'h0001;
                            end
                        end
                    end
                end
                ST_SEND: begin
                    if (dat_go) begin
                        tx_valid_q <= 1'b1;
                        tx_kind_q <= `CMF_KIND_DATA;
                        tx_sof_q <= first_q ? `CMF_SOF_I2 : `CMF_SOF_N2;
                        tx_eof_q <= last_q ? `CMF_EOF_T : `CMF_EOF_N;
                        tx_seq_cnt_q <= seq_cnt_q;
                        tx_seq_id_q <= seq_id_q;
                        tx_ox_id_q <= ox_id_q;
                        tx_size_q <= size_q;
                        tx_reason_q <= 8'h00;
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (rx_ack) begin
                        st_q <= ST_IDLE;
                        snd_busy_q <= 1'b0;
                    end else if (rx_busy) begin
                        if (tries_q < retry_limit) begin
                            tries_q <= tries_q + 4'h1;
                            st_q <= ST_SEND;
                        end else begin
                            st_q <= ST_IDLE;
                            snd_busy_q <= 1'b0;
                            snd_err_q <= 1'b1;
                        end
                    end else if (rx_reject) begin
                        st_q <= ST_IDLE; // Rejects are final, never resent
                        snd_busy_q <= 1'b0;
                        snd_err_q <= 1'b1;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                    snd_busy_q <= 1'b0;
                end
            endcase
            if (ack_go) begin
                tx_valid_q <= 1'b1;
                tx_kind_q <= ack_rjt_q ? `CMF_KIND_PRJT : `CMF_KIND_ACK;
                tx_sof_q <= ack_sof_q;
                tx_eof_q <= ack_eof_q;
                tx_reason_q <= ack_rjt_q ? `CMF_RSN_CLASS : 8'h00;
            end
        end
    end

    // ----------------
    // Receive path: acknowledge, reject, drop
    // ----------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_pend_q <= 1'b0;
            ack_rjt_q <= 1'b0;
            ack_last_q <= 1'b0;
            ack_sof_q <= 4'h0;
            ack_eof_q <= 4'h0;
            chk_q <= 1'b0;
            chk_qual_q <= 4'h0;
            chk_cnt_q <= 16'h0000;
            chk_last_q <= 1'b0;
            rx_deliver_q <= 1'b0;
            rx_dup_q <= 1'b0;
            tx_rrdy_q <= 1'b0;
        end else begin
            rx_deliver_q <= 1'b0;
            rx_dup_q <= 1'b0;
            tx_rrdy_q <= rx_buf_free;
            chk_q <= rx_take;
            chk_qual_q <= rx_qual;
            chk_cnt_q <= rx_seq_cnt;
            chk_last_q <= (rx_eof == `CMF_EOF_T);
            if (ack_go) begin
                ack_pend_q <= 1'b0;
            end
            // A new answer overwrites the slot even if one is still queued; later frames are not held upstream.
            if (chk_q) begin
                rx_deliver_q <= !trk_dup;
                rx_dup_q <= trk_dup;
                ack_pend_q <= 1'b1;
                ack_rjt_q <= 1'b0;
                ack_sof_q <= `CMF_SOF_N2;
                ack_eof_q <= chk_last_q ? `CMF_EOF_T : `CMF_EOF_N;
                ack_last_q <= chk_last_q;
            end else if (rx_valid && rx_frame_ok && rx_c1) begin
                ack_pend_q <= 1'b1;
                ack_rjt_q <= 1'b1;
                ack_sof_q <= `CMF_SOF_N1;
                ack_eof_q <= (rx_sof == `CMF_SOF_C1) ? `CMF_EOF_DT : `CMF_EOF_N;
                ack_last_q <= 1'b0;
            end
            // Datagram frames fall through unanswered; only the buffer release returns.
        end
    end

    // ----------------
    // Credit counters
    // ----------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bb_credit_q <= 8'h00;
            ee_credit_q <= 8'h00;
        end else if (credit_load) begin
            bb_credit_q <= bb_credit_login;
            ee_credit_q <= ee_credit_login;
        end else begin
            // Restore and consume in one cycle cancel out.
            bb_credit_q <= bb_credit_q + {7'h00, rx_rrdy} - {7'h00, (dat_go | ack_go)};
            ee_credit_q <= ee_credit_q + {7'h00, rx_ack} - {7'h00, dat_go};
        end
    end
endmodule // cmf_frame_service

/* rtl/cmf_track_mem.v */
// Small memory of received sequence-count marks, one word per slot.
// Assumes single clock; read data is registered.
`timescale 1ns/1ps
module cmf_track_mem (
    input wire clk_sys, // System clock
    input wire rst, // Async reset, active high
    input wire wr_en, // Write strobe
    input wire [3:0] wr_addr, // Write slot
    input wire [15:0] wr_data, // Write word
    input wire [3:0] rd_addr, // Read slot
    output reg [15:0] rd_data_q // Registered read word
);
    reg [15:0] mem [0:15];
    reg [15:0] vld_q; // Slot written since reset

    always @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Words are unknown until written, so a flag per slot masks them
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vld_q <= 16'h0000;
            rd_data_q <= 16'h0000;
        end else begin
            if (wr_en) begin
                vld_q[wr_addr] <= 1'b1;
            end
            rd_data_q <= vld_q[rd_addr] ? mem[rd_addr] : 16'h0000;
        end
    end
endmodule // cmf_track_mem
